//--- afmt_pkg.sv
package afmt_pkg;
  localparam int          SAMPLE_W      = 12;
  localparam logic [11:0] FS_POS_OB     = 12'hfff;
  localparam logic [11:0] FS_POS_TC     = 12'h7ff;
  localparam logic [11:0] FS_NEG_OB     = 12'h000;
  localparam logic [11:0] FS_NEG_TC     = 12'h800;

  // format select code: bit 1 picks two's complement, bit 0 picks falling-edge capture
  localparam int          FMT_W         = 2;
  localparam int          FMT_CODE_BIT  = 1;
  localparam int          FMT_EDGE_BIT  = 0;

  // serial word: 4 address bits then 12 data bits, msb first
  localparam int          SER_WORD_BITS = 16;
  localparam int          SER_CNT_W     = 4;
  localparam logic [3:0]  SER_LAST      = 4'hf;
  localparam int          SER_ADDR_LSB  = 12;
  localparam logic [3:0]  MODE_REG_ADDR = 4'h0;
  localparam int          PD_BIT        = 0;
  localparam logic [11:0] MODE_RESET    = 12'h000;

  localparam int          ADR_W         = 8;
  localparam logic [7:0]  ADR_STATUS    = 8'h00;
  localparam logic [7:0]  ADR_MASK      = 8'h04;
  localparam logic [7:0]  ADR_MODE      = 8'h08;
  localparam logic [7:0]  ADR_SAMPLE    = 8'h0c;

  localparam int          IRQ_W         = 2;
  localparam int          ST_RANGE_BIT  = 0;
  localparam int          ST_SERIAL_BIT = 1;
  localparam logic [1:0]  STATUS_RESET  = 2'h0;
  localparam logic [1:0]  MASK_RESET    = 2'h0;

  localparam int          PIN_W         = 6;
  localparam int          PIN_SER_DIN   = 0;
  localparam int          PIN_SER_SEL   = 1;
  localparam int          PIN_SCLK      = 2;
  localparam int          PIN_OE        = 3;
  localparam int          PIN_FMT_LSB   = 4;

  typedef enum logic [1:0] {
    SER_IDLE  = 2'b01,
    SER_SHIFT = 2'b10
  } afmt_ser_t;
endpackage : afmt_pkg

//--- afmt_code_if.sv
`timescale 1ns/1ps
interface afmt_code_if;
  logic [11:0] raw;
  logic        pos_over;
  logic        neg_over;
  logic        twos;
  logic [11:0] word;
  logic        at_limit;

  modport coder (input raw, input pos_over, input neg_over, input twos,
                 output word, output at_limit);
  modport user  (output raw, output pos_over, output neg_over, output twos,
                 input word, input at_limit);
endinterface : afmt_code_if

//--- afmt_coder.sv
`timescale 1ns/1ps
module afmt_coder (
  afmt_code_if.coder cif
);
  wire [11:0] ob_word;
  wire [11:0] tc_word;

  // positive overdrive wins if the core ever flags both at once
  assign ob_word = cif.pos_over ? afmt_pkg::FS_POS_OB :
                   cif.neg_over ? afmt_pkg::FS_NEG_OB :
                   cif.raw;
  assign tc_word = cif.pos_over ? afmt_pkg::FS_POS_TC :
                   cif.neg_over ? afmt_pkg::FS_NEG_TC :
                   {~cif.raw[11], cif.raw[10:0]};

  assign cif.word     = cif.twos ? tc_word : ob_word;
  // both codings hit full scale exactly when the offset word does
  assign cif.at_limit = (ob_word == afmt_pkg::FS_POS_OB) ||
                        (ob_word == afmt_pkg::FS_NEG_OB);
endmodule : afmt_coder

//--- afmt_top.sv
// Overview of operation
// - each result leaves as a 12-bit parallel word with the msb on the top line.
// - the out-of-range flag is 1 while the word sits at either full-scale limit, else 0.
// - the format select code picks one of four modes: coding and capture edge.
// - the receiver latches on the chosen ready-clock edge and data is aligned to that edge.
// - outside reset, data outputs float while output enable is low and are driven while it is high and power-down is clear.
// - positive overdrive gives 0xfff in offset binary and 0x7ff in two's complement.
// - negative overdrive gives 0x000 in offset binary and 0x800 in two's complement.
// - reset clears every internal mode register to zero.
// - data outputs are forced low for as long as reset is asserted.
// - mode registers are written only through the three-wire serial port.
// - the power-down mode bit floats the outputs.
`timescale 1ns/1ps
module afmt_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  output      logic        irq_o,
  input  wire logic [11:0] sample_i,
  input  wire logic        sample_valid_i,
  input  wire logic        pos_overdrive_i,
  input  wire logic        neg_overdrive_i,
  input  wire logic [1:0]  format_select_pin_i,
  input  wire logic        output_enable_i,
  input  wire logic        serial_clock_pin_i,
  input  wire logic        serial_select_pin_i,
  input  wire logic        serial_input_line_i,
  output      logic [11:0] data_o,
  output      logic        data_oe_o,
  output      logic        data_ready_clock_o,
  output      logic        out_of_range_flag_o,
  output      logic        power_down_o
);
  // pin synchronisers
  logic [5:0]  pin_meta;
  logic [5:0]  pin_sync;
  logic        sclk_prev;
  logic        sel_prev;

  // serial receiver
  afmt_pkg::afmt_ser_t ser_state;
  afmt_pkg::afmt_ser_t next_ser_state;
  logic [3:0]  ser_cnt;
  logic [3:0]  next_ser_cnt;
  logic [15:0] ser_shift;
  logic [15:0] next_ser_shift;
  logic        ser_commit;
  logic [11:0] mode_reg;

  // register file
  logic [1:0]  status;
  logic [1:0]  mask;
  logic        latch_pend;

  afmt_code_if cif ();

  afmt_coder u_coder (
    .cif (cif)
  );

  wire [1:0] fmt_sync  = pin_sync[afmt_pkg::PIN_FMT_LSB +: afmt_pkg::FMT_W];
  wire       oe_sync   = pin_sync[afmt_pkg::PIN_OE];
  wire       sclk_sync = pin_sync[afmt_pkg::PIN_SCLK];
  wire       sel_sync  = pin_sync[afmt_pkg::PIN_SER_SEL];
  wire       sdat_sync = pin_sync[afmt_pkg::PIN_SER_DIN];

  wire       twos_mode  = fmt_sync[afmt_pkg::FMT_CODE_BIT];
  wire       fall_latch = fmt_sync[afmt_pkg::FMT_EDGE_BIT];
  // data changes on the edge opposite to the one the receiver latches on
  wire       launch_lvl = fall_latch;
  wire       power_down = mode_reg[afmt_pkg::PD_BIT];
  wire       sclk_fall  = sclk_prev & ~sclk_sync;
  wire       sel_fall   = sel_prev & ~sel_sync;

  assign cif.raw      = sample_i;
  assign cif.pos_over = pos_overdrive_i;
  assign cif.neg_over = neg_overdrive_i;
  assign cif.twos    = twos_mode;

  assign power_down_o = power_down;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta  <= 6'h00;
      pin_sync  <= 6'h00;
      sclk_prev <= 1'b0;
      sel_prev  <= 1'b0;
    end else begin
      pin_meta  <= {format_select_pin_i, output_enable_i, serial_clock_pin_i,
                    serial_select_pin_i, serial_input_line_i};
      pin_sync  <= pin_meta;
      sclk_prev <= sclk_sync;
      sel_prev  <= sel_sync;
    end
  end

  // a frame opens on the falling edge of select and bits enter on falling serial clock;
  // a tied-low select never opens one, so default-mode boards cannot write by accident
  always_comb begin
    next_ser_state = ser_state;
    next_ser_cnt   = ser_cnt;
    next_ser_shift = ser_shift;
    ser_commit     = 1'b0;
    unique case (ser_state)
      afmt_pkg::SER_IDLE: begin
        if (sel_fall) begin
          next_ser_state = afmt_pkg::SER_SHIFT;
          next_ser_cnt   = 4'h0;
        end
      end
      afmt_pkg::SER_SHIFT: begin
        if (sel_sync) begin
          next_ser_state = afmt_pkg::SER_IDLE;
        end else if (sclk_fall) begin
          next_ser_shift = {ser_shift[14:0], sdat_sync};
          if (ser_cnt == afmt_pkg::SER_LAST) begin
            ser_commit     = 1'b1;
            next_ser_state = afmt_pkg::SER_IDLE;
          end else begin
            next_ser_cnt = ser_cnt + 4'h1;
          end
        end
      end
      default: begin
        next_ser_state = afmt_pkg::SER_IDLE;
      end
    endcase
  end

  wire mode_wr = ser_commit &&
                 (next_ser_shift[15:afmt_pkg::SER_ADDR_LSB] == afmt_pkg::MODE_REG_ADDR);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_state <= afmt_pkg::SER_IDLE;
      ser_cnt   <= 4'h0;
      ser_shift <= 16'h0000;
    end else begin
      ser_state <= next_ser_state;
      ser_cnt   <= next_ser_cnt;
      ser_shift <= next_ser_shift;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= afmt_pkg::MODE_RESET;
    end else if (mode_wr) begin
      mode_reg <= next_ser_shift[11:0];
    end
  end

  // wishbone slave: ack one cycle after the strobe, never two in a row
  wire        wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr     = wb_req & wb_we_i;
  wire        wb_rd     = wb_req & ~wb_we_i;
  wire        hit_stat  = (wb_adr_i == afmt_pkg::ADR_STATUS);
  wire        hit_mask  = (wb_adr_i == afmt_pkg::ADR_MASK);
  wire        hit_mode  = (wb_adr_i == afmt_pkg::ADR_MODE);
  wire        hit_samp  = (wb_adr_i == afmt_pkg::ADR_SAMPLE);
  wire        mask_wr   = wb_wr & hit_mask & wb_sel_i[0];
  wire        stat_clr  = wb_rd & hit_stat;
  wire [31:0] rd_mux    = hit_stat ? {30'h0, status} :
                          hit_mask ? {30'h0, mask} :
                          hit_mode ? {17'h0, oe_sync, fmt_sync, mode_reg} :
                          hit_samp ? {19'h0, out_of_range_flag_o, data_o} :
                          32'h0;

  wire [1:0]  events;
  assign events[afmt_pkg::ST_RANGE_BIT]  = sample_valid_i & cif.at_limit;
  assign events[afmt_pkg::ST_SERIAL_BIT] = ser_commit;
  // an event in the cycle of the clearing read survives it
  wire [1:0]  next_status = (stat_clr ? 2'h0 : status) | events;
  wire [1:0]  next_mask   = mask_wr ? wb_dat_i[1:0] : mask;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      status   <= afmt_pkg::STATUS_RESET;
      mask     <= afmt_pkg::MASK_RESET;
      irq_o    <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_rd ? rd_mux : 32'h0;
      status   <= next_status;
      mask     <= next_mask;
      irq_o    <= |(next_status & next_mask);
    end
  end

  // output stage: samples must be at least two clocks apart so each ready-clock
  // pulse completes before the next word launches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o              <= 12'h000;
      out_of_range_flag_o <= 1'b0;
      data_oe_o           <= 1'b1;
      data_ready_clock_o  <= 1'b0;
      latch_pend          <= 1'b0;
    end else begin
      if (sample_valid_i) begin
        data_o              <= cif.word;
        out_of_range_flag_o <= cif.at_limit;
      end
      data_oe_o <= oe_sync & ~power_down;
      if (sample_valid_i) begin
        data_ready_clock_o <= launch_lvl;
      end else if (latch_pend) begin
        data_ready_clock_o <= ~data_ready_clock_o;
      end
      latch_pend <= sample_valid_i;
    end
  end

  sequence s_word_out;
    sample_valid_i ##1 !sample_valid_i;
  endsequence

  sequence s_latch_edge;
    (data_ready_clock_o != $past(data_ready_clock_o)) && $stable(data_o);
  endsequence

  a_reset_low: assert property (@(posedge clk_i)
    rst_i |=> (data_o == 12'h000) && data_oe_o)
    else $error("data not forced low in reset");

  a_mode_clear: assert property (@(posedge clk_i)
    rst_i |=> (mode_reg == 12'h000))
    else $error("mode register not cleared by reset");

  a_oe_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> data_oe_o == $past(oe_sync & ~power_down))
    else $error("output enable does not follow pin");

  a_pd_float: assert property (@(posedge clk_i) disable iff (rst_i)
    power_down ##1 power_down |-> !data_oe_o)
    else $error("outputs driven in power down");

  a_pos_full: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_valid_i && pos_overdrive_i |=>
      data_o == ($past(twos_mode) ? 12'h7ff : 12'hfff))
    else $error("wrong positive full-scale code");

  a_neg_full: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_valid_i && neg_overdrive_i && !pos_overdrive_i |=>
      data_o == ($past(twos_mode) ? 12'h800 : 12'h000))
    else $error("wrong negative full-scale code");

  a_range_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_valid_i |=> out_of_range_flag_o == ($past(twos_mode) ?
      (data_o == 12'h7ff || data_o == 12'h800) :
      (data_o == 12'hfff || data_o == 12'h000)))
    else $error("range flag disagrees with word");

  a_twos_msb: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_valid_i && twos_mode && !pos_overdrive_i && !neg_overdrive_i |=>
      data_o == {~$past(sample_i[11]), $past(sample_i[10:0])})
    else $error("two's complement word not msb-inverted");

  a_bit_order: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_valid_i && !twos_mode && !pos_overdrive_i && !neg_overdrive_i |=>
      data_o == $past(sample_i))
    else $error("offset binary word reordered");

  a_clk_align: assert property (@(posedge clk_i) disable iff (rst_i)
    s_word_out |-> (data_ready_clock_o == $past(launch_lvl)) ##1 s_latch_edge)
    else $error("ready clock not aligned to data");

  a_serial_only: assert property (@(posedge clk_i) disable iff (rst_i)
    !mode_wr |=> $stable(mode_reg))
    else $error("mode register changed outside serial write");

  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(status & mask))
    else $error("interrupt does not follow status and mask");

endmodule : afmt_top

//--- afmt_rx_model.sv
`timescale 1ns/1ps
module afmt_rx_model (
  input  wire logic        ready_clock_i,
  input  wire logic        falling_i,
  input  wire logic [11:0] data_i,
  input  wire logic        flag_i,
  output      logic [11:0] word_o,
  output      logic        flag_o
);
  // only the chosen edge captures, so data aligned to the wrong edge shows up as a stale word
  always @(posedge ready_clock_i) begin
    if (!falling_i) begin
      word_o <= data_i;
      flag_o <= flag_i;
    end
  end

  always @(negedge ready_clock_i) begin
    if (falling_i) begin
      word_o <= data_i;
      flag_o <= flag_i;
    end
  end
endmodule : afmt_rx_model

//--- tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        sample_valid_i, pos_overdrive_i, neg_overdrive_i, output_enable_i;
  logic [11:0] sample_i, data_o, pin_data, rx_word;
  logic [1:0]  format_select_pin_i;
  logic        serial_clock_pin_i, serial_select_pin_i, serial_input_line_i;
  logic        data_oe_o, data_ready_clock_o, out_of_range_flag_o, power_down_o, rx_flag;
  int          errors, n_tests;

  afmt_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .sample_i, .sample_valid_i, .pos_overdrive_i,
    .neg_overdrive_i, .format_select_pin_i, .output_enable_i, .serial_clock_pin_i,
    .serial_select_pin_i, .serial_input_line_i, .data_o, .data_oe_o, .data_ready_clock_o,
    .out_of_range_flag_o, .power_down_o);

  afmt_rx_model u_rx (.ready_clock_i(data_ready_clock_o),
    .falling_i(format_select_pin_i[afmt_pkg::FMT_EDGE_BIT]), .data_i(pin_data),
    .flag_i(out_of_range_flag_o), .word_o(rx_word), .flag_o(rx_flag));

  // a released bus shows the inverse, so a floating output never passes for data
  assign pin_data = data_oe_o ? data_o : ~data_o;

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic complete_run;
    $display("tests %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc_n

  task automatic wb_acc(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    chk(wb_ack_o, 32'h1, "bus ack");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_acc

  task automatic rd(input logic [7:0] adr, output logic [31:0] q);
    wb_acc(1'b0, adr, 32'h0, q);
  endtask : rd

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] q;
    wb_acc(1'b1, adr, dat, q);
  endtask : wr

  // valid pulses stay well apart so the ready clock completes both phases
  task automatic push(input logic [11:0] s, input logic p, input logic n);
    @(posedge clk_i);
    sample_i        <= s;
    sample_valid_i  <= 1'b1;
    pos_overdrive_i <= p;
    neg_overdrive_i <= n;
    @(posedge clk_i);
    sample_valid_i  <= 1'b0;
    pos_overdrive_i <= 1'b0;
    neg_overdrive_i <= 1'b0;
    cyc_n(2);
  endtask : push

  task automatic ser(input logic [15:0] w);
    serial_select_pin_i <= 1'b0;
    cyc_n(4);
    for (int i = 15; i >= 0; i--) begin
      serial_input_line_i <= w[i];
      cyc_n(4);
      serial_clock_pin_i <= 1'b0;
      cyc_n(4);
      serial_clock_pin_i <= 1'b1;
      cyc_n(4);
    end
    serial_select_pin_i <= 1'b1;
    cyc_n(8);
  endtask : ser

  task automatic test_reset;
    logic [31:0] q;
    rd(afmt_pkg::ADR_STATUS, q);
    chk(q, 32'h0, "status after reset");
    rd(afmt_pkg::ADR_MASK, q);
    chk(q, 32'h0, "mask after reset");
    rd(afmt_pkg::ADR_MODE, q);
    chk(q[11:0], 32'h0, "mode after reset");
    $display("test reset done");
  endtask : test_reset

  task automatic test_formats;
    logic [11:0] smp [4] = '{12'h5a3, 12'hfff, 12'h123, 12'h456};
    logic [11:0] exp;
    logic [31:0] q;
    for (int f = 0; f < 4; f++) begin
      for (int k = 0; k < 4; k++) begin
        format_select_pin_i <= 2'(f);
        cyc_n(4);
        push(smp[k], k == 2, k == 3);
        exp = (k == 2) ? 12'hfff : (k == 3) ? 12'h000 : smp[k];
        if (f[afmt_pkg::FMT_CODE_BIT])
          exp[11] = ~exp[11];
        chk(data_o, exp, "output word");
        chk(out_of_range_flag_o, k != 0, "range flag");
        chk(rx_word, exp, "captured word");
        chk(rx_flag, k != 0, "captured flag");
        rd(afmt_pkg::ADR_SAMPLE, q);
        chk(q, {19'h0, k != 0, exp}, "sample register");
      end
    end
    $display("test formats done");
  endtask : test_formats

  task automatic test_irq;
    logic [31:0] q;
    wr(afmt_pkg::ADR_MASK, 32'h0);
    rd(afmt_pkg::ADR_STATUS, q);
    push(12'h100, 1'b1, 1'b0);
    chk(irq_o, 32'h0, "masked irq");
    wr(afmt_pkg::ADR_MASK, 32'h1);
    chk(irq_o, 32'h1, "unmasked irq");
    rd(afmt_pkg::ADR_STATUS, q);
    chk(q, 32'h1, "range event");
    chk(irq_o, 32'h0, "irq after clear");
    wr(afmt_pkg::ADR_STATUS, 32'h3);
    rd(afmt_pkg::ADR_STATUS, q);
    chk(q, 32'h0, "status cleared");
    rd(afmt_pkg::ADR_MASK, q);
    chk(q, 32'h1, "mask readback");
    wr(8'h10, 32'hffffffff);
    rd(8'h10, q);
    chk(q, 32'h0, "unmapped read");
    $display("test irq done");
  endtask : test_irq

  task automatic test_oe;
    output_enable_i <= 1'b0;
    cyc_n(5);
    chk(data_oe_o, 32'h0, "outputs released");
    output_enable_i <= 1'b1;
    cyc_n(5);
    chk(data_oe_o, 32'h1, "outputs driven");
    $display("test oe done");
  endtask : test_oe

  task automatic test_serial;
    logic [31:0] q;
    serial_select_pin_i <= 1'b1;
    cyc_n(4);
    ser(16'h1001);
    chk(power_down_o, 32'h0, "foreign address ignored");
    ser(16'h0001);
    chk(power_down_o, 32'h1, "power down set");
    chk(data_oe_o, 32'h0, "power down floats");
    wr(afmt_pkg::ADR_MODE, 32'h0);
    rd(afmt_pkg::ADR_MODE, q);
    chk(q[11:0], 32'h1, "mode only by serial");
    rd(afmt_pkg::ADR_STATUS, q);
    chk(q[1], 32'h1, "serial event");
    rst_i <= 1'b1;
    cyc_n(50);
    chk(data_o, 32'h0, "low in reset");
    chk(data_oe_o, 32'h1, "driven in reset");
    chk(power_down_o, 32'h0, "mode cleared");
    rst_i <= 1'b0;
    rd(afmt_pkg::ADR_MODE, q);
    chk(q[11:0], 32'h0, "mode after reset");
    $display("test serial done");
  endtask : test_serial

  initial begin
    errors = 0;
    n_tests = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, sample_valid_i, pos_overdrive_i, neg_overdrive_i} = '0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    sample_i = 12'h000;
    format_select_pin_i = 2'h0;
    output_enable_i = 1'b1;
    serial_clock_pin_i = 1'b1;
    serial_select_pin_i = 1'b0;
    serial_input_line_i = 1'b0;
    cyc_n(19);
    chk(data_o, 32'h0, "low in reset");
    cyc_n(1);
    rst_i <= 1'b0;
    test_reset();
    test_formats();
    test_irq();
    test_oe();
    test_serial();
    complete_run();
  end

  initial begin
    cyc_n(20000);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : tb
